// *** hw/frs_defs.vh ***
// Constants for the fieldbus remote station I/O map
`ifndef FRS_DEFS_VH
`define FRS_DEFS_VH

// Clock and input filter timing
`define FRS_CLK_HZ          10000000
`define FRS_FILTER_MS       10
// 10 ms of the 10 MHz clock, sized to the filter counter
`define FRS_FILTER_CYCLES   17'h186A0
`define FRS_FILTER_CNT_W    17
`define FRS_HOLD_MS         30

// Station geometry
`define FRS_STATIONS        4
`define FRS_BITS            128
`define FRS_RW_WORDS        16
`define FRS_RW_WIDTH        16
`define FRS_RW_AW           4
`define FRS_STATION_MIN     1
`define FRS_STATION_MAX     64

// Link rate codes
`define FRS_RATE_10M        3'h0
`define FRS_RATE_5M         3'h1
`define FRS_RATE_2M5        3'h2
`define FRS_RATE_625K       3'h3
`define FRS_RATE_156K       3'h4

// Bit positions in the station's 128-bit slice, 16 * word + bit
`define FRS_B_SYS_LO        0
`define FRS_B_GP_LO         8
`define FRS_B_JOG_LO        72
`define FRS_B_CMD           104
`define FRS_B_CMD_ERR       105
`define FRS_B_SEL_LO        108

// System bit indexes
`define FRS_SYS_HOME        0
`define FRS_SYS_START       1
`define FRS_SYS_STOP        2
`define FRS_SYS_CLEAR       3

// Register byte addresses
`define FRS_REG_CTRL        8'h00
`define FRS_REG_SYS_OUT     8'h04
`define FRS_REG_SYS_IN      8'h08
`define FRS_REG_GP_OUT_LO   8'h0C
`define FRS_REG_GP_OUT_HI   8'h10
`define FRS_REG_GP_IN_LO    8'h14
`define FRS_REG_GP_IN_HI    8'h18
`define FRS_REG_JOG         8'h1C
`define FRS_REG_CMD         8'h20
`define FRS_REG_LINK        8'h24
`define FRS_REG_RWR_BASE    8'h40
`define FRS_REG_RWW_BASE    8'h80

// Reset values
`define FRS_RST_CTRL        1'h0

`endif

// *** hw/frs_wordmem.v ***
// Small word memory with one write port and one registered read port
`timescale 1ns/1ns
module frs_wordmem #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   // Clock
   input  wire             mclk_in,
   // Write port
   input  wire             we_in,
   input  wire [AW-1:0]    waddr_in,
   input  wire [WIDTH-1:0] wdata_in,
   // Read port
   input  wire [AW-1:0]    raddr_in,
   output wire [WIDTH-1:0] rdata_out
);

   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [WIDTH-1:0] rdata_reg;
   integer         k;

   // Contents start at zero so the far side never reads unknowns
   initial begin
      for (k = 0; k < DEPTH; k = k + 1) begin
         mem_reg[k] = {WIDTH{1'b0}};
      end
      rdata_reg = {WIDTH{1'b0}};
   end

   always @(posedge mclk_in) begin
      if (we_in) begin
         mem_reg[waddr_in] <= wdata_in;
      end
      rdata_reg <= mem_reg[raddr_in];
   end

   assign rdata_out = rdata_reg;

endmodule // frs_wordmem

// *** hw/frs_station.v ***
// Remote device station I/O map: filters, safe state, handshake, indicators
//
// Summary of operation
// - Occupies four stations: 128 RX, 128 RY bits, 16 RWw and 16 RWr words.
// - Link rate 10M, 5M, 2.5M, 625k or 156k, chosen by parameter.
// - Station number 1 to 64 set by parameter.
// - Base word index n equals two times (station number minus one).
// - Word data moves through RWw/RWr; RX/RY bits act as handshake.
// - Device answer bits are set by a software write and cleared automatically.
// - RXn0-3 running/error/positioned/homed; RYn0-3 home/start/stop/clear requests.
// - Eight 8-bit output ports on RXn8 onward, input ports on RYn8 onward.
// - Jog status on RX(n+4)8-F, jog requests on RY(n+4)8-F.
// - Master requests on RY(n+6)8; device answers finish RX(n+6)8, error RX(n+6)9.
// - Four-bit selection from RY(n+6)C-F echoed on RX(n+6)C-F.
// - Link lost: stop request forced to 1, all other received bits 0.
// - Teach pendant in control: link lost clears stop request too.
// - Received control bits change internally only after 10 ms stable.
// - Received pulses shorter than 10 ms cause no internal change.
// - Receive indicator lit while a frame is received.
// - Send indicator lit while a frame is transmitted.
// - Fault indicator on CRC error, bad rate or bad station number.
// - Link-ok indicator lit normally, off on timeout or network stop.
// - Highest jog request bit low means positive, high means negative.
`timescale 1ns/1ns
`include "frs_defs.vh"
module frs_station #(
   parameter       [6:0]                    STATION_NO    = 7'h01,
   parameter       [2:0]                    LINK_RATE     = `FRS_RATE_10M,
   parameter       [`FRS_FILTER_CNT_W-1:0]  FILTER_CYCLES = `FRS_FILTER_CYCLES
) (
   // Clock and reset
   input  wire                  mclk_in,
   input  wire                  rst_in,
   // Avalon-MM register slave
   input  wire [7:0]            avs_address_in,
   input  wire                  avs_read_in,
   input  wire                  avs_write_in,
   input  wire [31:0]           avs_writedata_in,
   input  wire [3:0]            avs_byteenable_in,
   output wire [31:0]           avs_readdata_out,
   output wire                  avs_waitrequest_out,
   // Link engine: bit slices relative to base word n
   input  wire [127:0]          link_ry_in,
   output wire [127:0]          link_rx_out,
   output wire [6:0]            link_base_word_out,
   output wire [2:0]            link_rate_out,
   // Link engine: remote register words
   input  wire                  link_rww_we_in,
   input  wire [3:0]            link_rww_addr_in,
   input  wire [15:0]           link_rww_data_in,
   input  wire [3:0]            link_rwr_addr_in,
   output wire [15:0]           link_rwr_data_out,
   // Link engine: frame and error status
   input  wire                  link_rx_busy_in,
   input  wire                  link_tx_busy_in,
   input  wire                  link_crc_err_in,
   input  wire                  link_frame_ok_in,
   input  wire                  link_timeout_in,
   input  wire                  link_stopped_in,
   // Status indicators
   output wire                  recv_indicator_out,
   output wire                  send_indicator_out,
   output wire                  fault_indicator_out,
   output wire                  link_ok_indicator_out,
   // Decoded jog direction for the axis logic
   output wire                  jog_dir_neg_out
);

   localparam NFILT = 81;

   // Byte-enable merge, used by the GP output and jog registers
   function [31:0] be_merge;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0]  be;
      integer      b;
      begin
         be_merge = old_val;
         for (b = 0; b < 4; b = b + 1) begin
            if (be[b]) begin
               be_merge[b*8 +: 8] = new_val[b*8 +: 8];
            end
         end
      end
   endfunction

   // Register address hit test for the bus
   function addr_hit;
      input [7:0] addr;
      input [7:0] reg_addr;
      begin
         addr_hit = (addr == reg_addr);
      end
   endfunction

   // Configuration checks
   wire       station_ok = (STATION_NO >= `FRS_STATION_MIN) &&
                           (STATION_NO <= `FRS_STATION_MAX);
   wire       rate_ok    = (LINK_RATE <= `FRS_RATE_156K);
   wire [6:0] base_word  = {STATION_NO[5:0] - 6'h01, 1'b0};

   assign link_base_word_out = base_word;
   assign link_rate_out      = LINK_RATE;

   // Bus slave state
   reg  [1:0]  phase_reg;
   reg  [31:0] rdata_reg;
   reg         ctrl_tp_reg;
   reg  [3:0]  sys_out_reg;
   reg  [63:0] gp_out_reg;
   reg  [7:0]  jog_out_reg;
   reg         crc_seen_reg;

   // Command handshake state
   reg         cmd_req_d_reg;
   reg         cmd_pending_reg;
   reg         cmd_finish_reg;
   reg         cmd_err_reg;
   reg  [3:0]  sel_accept_reg;
   reg  [127:0] rx_reg;

   wire        bus_req   = avs_read_in | avs_write_in;
   wire        bus_done  = bus_req & (phase_reg == 2'h2);
   wire        wr_en     = avs_write_in & bus_done;
   wire [31:0] wd        = avs_writedata_in;
   wire [3:0]  be        = avs_byteenable_in;

   assign avs_waitrequest_out = bus_req & (phase_reg != 2'h2);
   assign avs_readdata_out    = rdata_reg;

   // Received bits in use; reserved and prohibited RY bits are never looked at
   wire [NFILT-1:0] ry_raw = {link_ry_in[`FRS_B_SEL_LO +: 4],
                              link_ry_in[`FRS_B_CMD],
                              link_ry_in[`FRS_B_GP_LO +: 72],
                              link_ry_in[`FRS_B_SYS_LO +: 4]};
   wire [NFILT-1:0] ry_filt;

   // One counter per bit; any bounce restarts the wait
   genvar gi;
   generate
      for (gi = 0; gi < NFILT; gi = gi + 1) begin : g_filt
         reg [`FRS_FILTER_CNT_W-1:0] cnt_reg;
         reg                         lvl_reg;
         always @(posedge mclk_in) begin
            if (rst_in) begin
               cnt_reg <= {`FRS_FILTER_CNT_W{1'b0}};
               lvl_reg <= 1'b0;
            end else if (ry_raw[gi] == lvl_reg) begin
               cnt_reg <= {`FRS_FILTER_CNT_W{1'b0}};
            end else if (cnt_reg == FILTER_CYCLES - 1'b1) begin
               cnt_reg <= {`FRS_FILTER_CNT_W{1'b0}};
               lvl_reg <= ry_raw[gi];
            end else begin
               cnt_reg <= cnt_reg + 1'b1;
            end
         end
         assign ry_filt[gi] = lvl_reg;
      end
   endgenerate

   // Link health; the filter keeps running, only its result is overridden
   wire link_up = ~link_timeout_in & ~link_stopped_in & station_ok & rate_ok;

   wire [NFILT-1:0] lost_pattern = {{(NFILT-3){1'b0}}, ~ctrl_tp_reg, 2'h0};
   wire [NFILT-1:0] ry_eff       = link_up ? ry_filt : lost_pattern;

   wire [3:0]  sys_in   = ry_eff[3:0];
   wire [63:0] gp_in    = ry_eff[67:4];
   wire [7:0]  jog_in   = ry_eff[75:68];
   wire        cmd_req  = ry_eff[76];
   wire [3:0]  sel_in   = ry_eff[80:77];

   assign jog_dir_neg_out = jog_in[7];

   // Indicators
   assign recv_indicator_out    = link_rx_busy_in;
   assign send_indicator_out    = link_tx_busy_in;
   assign fault_indicator_out   = crc_seen_reg | ~station_ok | ~rate_ok;
   assign link_ok_indicator_out = link_up;

   // CRC fault holds until a good frame; a new error in that cycle wins
   always @(posedge mclk_in) begin
      if (rst_in) begin
         crc_seen_reg <= 1'b0;
      end else if (link_crc_err_in) begin
         crc_seen_reg <= 1'b1;
      end else if (link_frame_ok_in) begin
         crc_seen_reg <= 1'b0;
      end
   end

   // Remote register words: RWr written by software, RWw by the link
   wire        rwr_we   = wr_en & (avs_address_in[7:6] == 2'h1);
   wire [15:0] rww_rdata;

   frs_wordmem #(
      .WIDTH (`FRS_RW_WIDTH),
      .DEPTH (`FRS_RW_WORDS),
      .AW    (`FRS_RW_AW)
   ) u_rwr (
      .mclk_in   (mclk_in),
      .we_in     (rwr_we),
      .waddr_in  (avs_address_in[5:2]),
      .wdata_in  (wd[15:0]),
      .raddr_in  (link_rwr_addr_in),
      .rdata_out (link_rwr_data_out)
   );

   frs_wordmem #(
      .WIDTH (`FRS_RW_WIDTH),
      .DEPTH (`FRS_RW_WORDS),
      .AW    (`FRS_RW_AW)
   ) u_rww (
      .mclk_in   (mclk_in),
      .we_in     (link_rww_we_in),
      .waddr_in  (link_rww_addr_in),
      .wdata_in  (link_rww_data_in),
      .raddr_in  (avs_address_in[5:2]),
      .rdata_out (rww_rdata)
   );

   // Read mux; unmapped addresses read zero
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      if (avs_address_in[7:6] == 2'h2) begin
         rd_mux = {16'h0000, rww_rdata};
      end else if (addr_hit(avs_address_in, `FRS_REG_CTRL)) begin
         rd_mux = {31'h00000000, ctrl_tp_reg};
      end else if (addr_hit(avs_address_in, `FRS_REG_SYS_OUT)) begin
         rd_mux = {28'h0000000, sys_out_reg};
      end else if (addr_hit(avs_address_in, `FRS_REG_SYS_IN)) begin
         rd_mux = {28'h0000000, sys_in};
      end else if (addr_hit(avs_address_in, `FRS_REG_GP_OUT_LO)) begin
         rd_mux = gp_out_reg[31:0];
      end else if (addr_hit(avs_address_in, `FRS_REG_GP_OUT_HI)) begin
         rd_mux = gp_out_reg[63:32];
      end else if (addr_hit(avs_address_in, `FRS_REG_GP_IN_LO)) begin
         rd_mux = gp_in[31:0];
      end else if (addr_hit(avs_address_in, `FRS_REG_GP_IN_HI)) begin
         rd_mux = gp_in[63:32];
      end else if (addr_hit(avs_address_in, `FRS_REG_JOG)) begin
         rd_mux = {15'h0000, jog_in[7], jog_in, jog_out_reg};
      end else if (addr_hit(avs_address_in, `FRS_REG_CMD)) begin
         rd_mux = {24'h000000, sel_accept_reg, cmd_err_reg, cmd_finish_reg,
                   cmd_pending_reg, cmd_req};
      end else if (addr_hit(avs_address_in, `FRS_REG_LINK)) begin
         rd_mux = {13'h0000, LINK_RATE, 1'b0, STATION_NO, 4'h0,
                   link_ok_indicator_out, fault_indicator_out,
                   send_indicator_out, recv_indicator_out};
      end
   end

   // Bus phases: 0 idle, 1 memory read settling, 2 answer
   always @(posedge mclk_in) begin
      if (rst_in) begin
         phase_reg <= 2'h0;
         rdata_reg <= 32'h00000000;
      end else if (!bus_req || phase_reg == 2'h2) begin
         phase_reg <= 2'h0;
      end else if (phase_reg == 2'h1) begin
         phase_reg <= 2'h2;
         rdata_reg <= avs_read_in ? rd_mux : 32'h00000000;
      end else begin
         phase_reg <= 2'h1;
      end
   end

   // Software-written registers
   reg [31:0] gp_lo_next;
   reg [31:0] gp_hi_next;
   reg [31:0] misc_next;
   always @* begin
      gp_lo_next = be_merge(gp_out_reg[31:0], wd, be);
      gp_hi_next = be_merge(gp_out_reg[63:32], wd, be);
      misc_next  = be_merge({24'h000000, jog_out_reg}, wd, be);
   end

   always @(posedge mclk_in) begin
      if (rst_in) begin
         ctrl_tp_reg <= `FRS_RST_CTRL;
         sys_out_reg <= 4'h0;
         gp_out_reg  <= 64'h0000000000000000;
         jog_out_reg <= 8'h00;
      end else if (wr_en) begin
         if (addr_hit(avs_address_in, `FRS_REG_CTRL) && be[0]) begin
            ctrl_tp_reg <= wd[0];
         end
         if (addr_hit(avs_address_in, `FRS_REG_SYS_OUT) && be[0]) begin
            sys_out_reg <= wd[3:0];
         end
         if (addr_hit(avs_address_in, `FRS_REG_GP_OUT_LO)) begin
            gp_out_reg[31:0] <= gp_lo_next;
         end
         if (addr_hit(avs_address_in, `FRS_REG_GP_OUT_HI)) begin
            gp_out_reg[63:32] <= gp_hi_next;
         end
         if (addr_hit(avs_address_in, `FRS_REG_JOG)) begin
            jog_out_reg <= misc_next[7:0];
         end
      end
   end

   // Command handshake, answered without software sequencing the bits
   wire cmd_rise = cmd_req & ~cmd_req_d_reg;
   wire cmd_fall = ~cmd_req & cmd_req_d_reg;
   wire cmd_wr   = wr_en & addr_hit(avs_address_in, `FRS_REG_CMD) & be[0];

   always @(posedge mclk_in) begin
      if (rst_in) begin
         cmd_req_d_reg   <= 1'b0;
         cmd_pending_reg <= 1'b0;
         cmd_finish_reg  <= 1'b0;
         cmd_err_reg     <= 1'b0;
         sel_accept_reg  <= 4'h0;
      end else begin
         cmd_req_d_reg <= cmd_req;
         if (cmd_rise) begin
            cmd_pending_reg <= 1'b1;
            cmd_finish_reg  <= 1'b0;
            cmd_err_reg     <= 1'b0;
            sel_accept_reg  <= sel_in;
         end else if (cmd_fall) begin
            // Request withdrawn: answer drops, ready for the next one
            cmd_pending_reg <= 1'b0;
            cmd_finish_reg  <= 1'b0;
            cmd_err_reg     <= 1'b0;
         end else if (cmd_wr && (wd[0] || wd[1]) && cmd_pending_reg) begin
            cmd_pending_reg <= 1'b0;
            cmd_finish_reg  <= 1'b1;
            cmd_err_reg     <= wd[1];
         end
      end
   end

   // Outgoing RX slice; every unassigned position stays zero
   reg [127:0] rx_next;
   always @* begin
      rx_next = {`FRS_BITS{1'b0}};
      rx_next[`FRS_B_SYS_LO +: 4] = sys_out_reg;
      rx_next[`FRS_B_GP_LO +: 64] = gp_out_reg;
      rx_next[`FRS_B_JOG_LO +: 8] = jog_out_reg;
      rx_next[`FRS_B_CMD]         = cmd_finish_reg;
      rx_next[`FRS_B_CMD_ERR]     = cmd_err_reg;
      rx_next[`FRS_B_SEL_LO +: 4] = sel_accept_reg;
   end

   always @(posedge mclk_in) begin
      if (rst_in) begin
         rx_reg <= {`FRS_BITS{1'b0}};
      end else begin
         rx_reg <= rx_next;
      end
   end

   assign link_rx_out = rx_reg;

endmodule // frs_station

// *** tb/frs_station_checker.sv ***
// Port assertions for the remote station I/O map
`timescale 1ns/1ns
module frs_station_checker #(
   parameter [6:0]  STATION_NO    = 7'h01,
   parameter [16:0] FILTER_CYCLES = 17'h186A0
) (
   // Clock and reset
   input wire         mclk_in,
   input wire         rst_in,
   // Link side
   input wire [127:0] link_ry_in,
   input wire [127:0] link_rx_out,
   input wire [6:0]   link_base_word_out,
   input wire         link_rx_busy_in,
   input wire         link_tx_busy_in,
   input wire         link_crc_err_in,
   input wire         link_frame_ok_in,
   input wire         link_timeout_in,
   input wire         link_stopped_in,
   // Indicators
   input wire         recv_indicator_out,
   input wire         send_indicator_out,
   input wire         fault_indicator_out,
   input wire         link_ok_indicator_out,
   input wire         jog_dir_neg_out
);
   localparam [127:0] RX_USED = 128'h0000_F300_0000_FFFF_FFFF_FFFF_FFFF_FF0F;
   reg [16:0] hi_cnt;
   // Run length of the raw jog direction bit, saturating
   always @(posedge mclk_in) begin
      if (rst_in || !link_ry_in[79])
         hi_cnt <= 17'h0;
      else if (hi_cnt != 17'h1FFFF)
         hi_cnt <= hi_cnt + 17'h1;
   end
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   property p_base; link_base_word_out == 7'(2 * (STATION_NO - 1)); endproperty
   a_base: assert property (p_base) else $error("base word wrong");
   property p_recv; recv_indicator_out == link_rx_busy_in; endproperty
   a_recv: assert property (p_recv) else $error("receive light wrong");
   property p_send; send_indicator_out == link_tx_busy_in; endproperty
   a_send: assert property (p_send) else $error("send light wrong");
   property p_crc; link_crc_err_in |=> fault_indicator_out; endproperty
   a_crc: assert property (p_crc) else $error("crc fault not shown");
   // A reset may clear the light, so only judge falls outside it
   property p_fault_rel;
      $fell(fault_indicator_out) && !$past(rst_in) |-> $past(link_frame_ok_in);
   endproperty
   a_fault_rel: assert property (p_fault_rel) else $error("fault cleared early");
   property p_lok; link_ok_indicator_out == !(link_timeout_in || link_stopped_in); endproperty
   a_lok: assert property (p_lok) else $error("link ok light wrong");
   property p_resv; (link_rx_out & ~RX_USED) == 128'h0; endproperty
   a_resv: assert property (p_resv) else $error("unused rx bit set");
   property p_filt; $rose(jog_dir_neg_out) |-> hi_cnt >= FILTER_CYCLES; endproperty
   a_filt: assert property (p_filt) else $error("filter passed too soon");
   property p_loss; link_timeout_in || link_stopped_in |-> !jog_dir_neg_out; endproperty
   a_loss: assert property (p_loss) else $error("jog kept on link loss");
   property p_cmd; link_rx_out[105] |-> link_rx_out[104]; endproperty
   a_cmd: assert property (p_cmd) else $error("error without finish");
   c_crc: cover property (link_crc_err_in);
   c_jog: cover property ($rose(jog_dir_neg_out));
   c_fin: cover property ($rose(link_rx_out[104]));
endmodule // frs_station_checker

bind frs_station frs_station_checker #(.STATION_NO(STATION_NO), .FILTER_CYCLES(FILTER_CYCLES))
u_chk (
   .mclk_in(mclk_in), .rst_in(rst_in), .link_ry_in(link_ry_in), .link_rx_out(link_rx_out),
   .link_base_word_out(link_base_word_out), .link_rx_busy_in(link_rx_busy_in),
   .link_tx_busy_in(link_tx_busy_in), .link_crc_err_in(link_crc_err_in),
   .link_frame_ok_in(link_frame_ok_in), .link_timeout_in(link_timeout_in),
   .link_stopped_in(link_stopped_in), .recv_indicator_out(recv_indicator_out),
   .send_indicator_out(send_indicator_out), .fault_indicator_out(fault_indicator_out),
   .link_ok_indicator_out(link_ok_indicator_out), .jog_dir_neg_out(jog_dir_neg_out));

// *** tb/frs_master_model.sv ***
// Master station model: drives received RY levels and RWw words
`timescale 1ns/1ns
module frs_master_model #(
   parameter HOLD = 24
) (
   // Clock
   input  wire         mclk_in,
   // Link data toward the station
   output reg  [127:0] ry_out,
   output reg          rww_we_out,
   output reg  [3:0]   rww_addr_out,
   output reg  [15:0]  rww_data_out
);
   localparam [127:0] USED = 128'h0000_F100_0000_FFFF_FFFF_FFFF_FFFF_FF0F;
   initial begin
      ry_out = 128'h0;
      rww_we_out = 1'b0;
      rww_addr_out = 4'h0;
      rww_data_out = 16'h0;
   end
   // Holds each level well past the filter so no change is lost
   task set_ry(input [127:0] v);
      begin
         @(posedge mclk_in);
         ry_out <= v & USED;
         repeat (HOLD) @(posedge mclk_in);
      end
   endtask
   // Deliberately too short a pulse
   task glitch(input [127:0] v, input integer n);
      begin
         @(posedge mclk_in);
         ry_out <= ry_out ^ (v & USED);
         repeat (n) @(posedge mclk_in);
         ry_out <= ry_out ^ (v & USED);
         repeat (HOLD) @(posedge mclk_in);
      end
   endtask
   task put_rww(input [3:0] a, input [15:0] d);
      begin
         @(posedge mclk_in);
         rww_we_out <= 1'b1;
         rww_addr_out <= a;
         rww_data_out <= d;
         @(posedge mclk_in);
         rww_we_out <= 1'b0;
      end
   endtask
endmodule // frs_master_model

// *** tb/tb.sv ***
// Testbench for the remote station I/O map
`timescale 1ns/1ns
module tb;
   localparam [16:0] FC   = 17'h00008;
   localparam [6:0]  STN  = 7'h05;
   localparam [2:0]  RATE = 3'h2;
   reg               mclk, rst, rd, wr, rxb, txb, crc, fok, tmo, stp;
   reg  [7:0]        addr;
   reg  [31:0]       wdat, rdat;
   reg  [3:0]        rwr_a, sel;
   wire [127:0]      ry, rx;
   wire              rww_we, wreq, recv, send, fault, lok, jdir;
   wire [3:0]        rww_a;
   wire [15:0]       rww_d, rwr_d;
   wire [31:0]       rdata;
   wire [6:0]        base;
   wire [2:0]        rate;
   integer           num_errors, n_compared, cyc, k;

   frs_station #(.STATION_NO(STN), .LINK_RATE(RATE), .FILTER_CYCLES(FC)) u_dut (
      .mclk_in(mclk), .rst_in(rst), .avs_address_in(addr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hF),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .link_ry_in(ry),
      .link_rx_out(rx), .link_base_word_out(base), .link_rate_out(rate),
      .link_rww_we_in(rww_we), .link_rww_addr_in(rww_a), .link_rww_data_in(rww_d),
      .link_rwr_addr_in(rwr_a), .link_rwr_data_out(rwr_d), .link_rx_busy_in(rxb),
      .link_tx_busy_in(txb), .link_crc_err_in(crc), .link_frame_ok_in(fok),
      .link_timeout_in(tmo), .link_stopped_in(stp), .recv_indicator_out(recv),
      .send_indicator_out(send), .fault_indicator_out(fault),
      .link_ok_indicator_out(lok), .jog_dir_neg_out(jdir));

   frs_master_model #(.HOLD(3 * FC)) u_m (
      .mclk_in(mclk), .ry_out(ry), .rww_we_out(rww_we), .rww_addr_out(rww_a),
      .rww_data_out(rww_d));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task results;
      begin
         if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         num_errors = num_errors + 1;
         results;
      end
   end

   task chk(input [127:0] got, input [127:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   // Waitrequest and read data taken at the rising edge; one idle edge between calls
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge mclk);
         addr <= a;
         wdat <= d;
         wr <= w;
         rd <= ~w;
         @(posedge mclk);
         while (wreq !== 1'b0)
            @(posedge mclk);
         rdat = rdata;
         rd <= 1'b0;
         wr <= 1'b0;
      end
   endtask

   initial begin
      {rst, rd, wr, rxb, txb, crc, fok, tmo, stp} = 9'h100;
      addr = 8'h0;
      wdat = 32'h0;
      rwr_a = 4'h0;
      num_errors = 0;
      n_compared = 0;
      cyc = 0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk(base, 7'h08);
      chk(rate, RATE);
      bus(0, 8'h24, 0);
      chk(rdat[14:8], STN);
      chk(rdat[3:0], 4'h8);
      bus(0, 8'h00, 0);
      chk(rdat, 32'h0);
      bus(1, 8'h30, 32'hFFFF_FFFF);
      bus(0, 8'h30, 0);
      chk(rdat, 32'h0);
      bus(1, 8'h04, 32'h0000_000A);
      bus(1, 8'h0C, 32'h1234_5678);
      bus(1, 8'h10, 32'h9ABC_DEF0);
      bus(1, 8'h1C, 32'h0000_00A5);
      repeat (2) @(posedge mclk);
      chk(rx[3:0], 4'hA);
      chk(rx[71:8], 64'h9ABC_DEF0_1234_5678);
      chk(rx[79:72], 8'hA5);
      u_m.set_ry({48'h0, 8'h80, 64'h0123_4567_89AB_CDEF, 8'h03});
      bus(0, 8'h08, 0);
      chk(rdat[3:0], 4'h3);
      bus(0, 8'h14, 0);
      chk(rdat, 32'h89AB_CDEF);
      bus(0, 8'h18, 0);
      chk(rdat, 32'h0123_4567);
      bus(0, 8'h1C, 0);
      chk(rdat[16:8], 9'h180);
      chk(jdir, 1'b1);
      u_m.glitch(128'h2, FC - 2);
      bus(0, 8'h08, 0);
      chk(rdat[3:0], 4'h3);
      tmo <= 1'b1;
      bus(0, 8'h08, 0);
      chk(rdat[3:0], 4'h4);
      bus(0, 8'h14, 0);
      chk(rdat, 32'h0);
      chk(lok, 1'b0);
      bus(1, 8'h00, 1);
      bus(0, 8'h08, 0);
      chk(rdat[3:0], 4'h0);
      bus(1, 8'h00, 0);
      tmo <= 1'b0;
      stp <= 1'b1;
      bus(0, 8'h08, 0);
      chk(rdat[3:0], 4'h4);
      chk(lok, 1'b0);
      stp <= 1'b0;
      rxb <= 1'b1;
      txb <= 1'b1;
      crc <= 1'b1;
      @(posedge mclk);
      crc <= 1'b0;
      @(posedge mclk);
      chk({recv, send, fault, lok}, 4'hF);
      {rxb, txb, fok} <= 3'h1;
      @(posedge mclk);
      fok <= 1'b0;
      @(posedge mclk);
      chk({recv, send, fault}, 3'h0);
      for (k = 0; k < 2; k = k + 1) begin
         sel = (k == 0) ? 4'h9 : 4'h6;
         u_m.set_ry({16'h0, sel, 4'h1, 104'h0});
         chk(jdir, 1'b0);
         chk(rx[111:104], {sel, 4'h0});
         bus(1, 8'h20, k + 1);
         // No longer pending, so this fail report must be ignored
         bus(1, 8'h20, 32'h0000_0002);
         bus(0, 8'h20, 0);
         chk(rdat[7:0], (k == 0) ? 8'h95 : 8'h6D);
         repeat (2) @(posedge mclk);
         chk(rx[105:104], (k == 0) ? 2'h1 : 2'h3);
         u_m.set_ry(128'h0);
         chk(rx[105:104], 2'h0);
      end
      u_m.put_rww(4'h3, 16'hBEEF);
      bus(0, 8'h8C, 0);
      chk(rdat[15:0], 16'hBEEF);
      bus(1, 8'h5C, 32'h0000_C0DE);
      rwr_a <= 4'h7;
      repeat (2) @(posedge mclk);
      chk(rwr_d, 16'hC0DE);
      results;
   end
endmodule // tb
